/* File: hw/zcf_top.sv */
`timescale 1ns/1ps
// Operation
// (R01) Z event fires after zef+1 consecutive valid samples, 1 to 16.
// (R02) Z samples come from the sample clock or PWM period strobe.
// (R03) In sensorless mode each D event starts a blanking window that ignores Z detection.
// (R04) Sensorless: 5-40us by 5us, then 60-200us by 20us; else none.
// (R05) All durations count peripheral ticks derived from aclk.
// (R06) With motor output off, sampling gate bit enables Z sampling.
// (R07) Software writes zero to sampling register bits 6 to 4.
// (R08) Sample rate field picks 1 MHz, 500, 250 or 125 kHz.
// (R09) Capture source bit picks RTC interrupt or timer high read.
// (R10) Unused inputs grounded or high-Z only in plain sensorless setup.
// (R11) Reset loads filter config 0Fh and sampling config 00h.
// (R12) Independent phase config disables the unused input selection.
// (R13) Tacho edge select 00 means position or sensorless mode.
// (R14) A sample without Z detection restarts the consecutive count.
module zcf_top #(
    parameter int PERIPH_DIV = zcf_pkg::PERIPH_DIV
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Motor side events
    input wire logic z_detect,
    input wire logic d_event,
    input wire logic pwm_period,
    input wire logic rtc_irq,
    input wire logic timer_high_read,
    // Results
    output logic z_event,
    output logic z_blanking,
    output logic encoder_capture,
    output logic unused_input_gnd,
    output logic unused_input_hiz
);

    // =========================================================
    // State
    // =========================================================
    typedef struct packed {
        logic [7:0] zf_cfg;
        logic [7:0] sc_cfg;
        logic [7:0] ctrl;
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [7:0] wdata;
        logic wstrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [5:0] pdiv;
        logic [5:0] presc;
        logic [9:0] win_cnt;
        logic blank;
        logic [4:0] run;
        logic z_event;
        logic enc_cap;
        logic gnd;
        logic hiz;
    } zcf_state_t;

    localparam logic [5:0] PDIV_LAST = 6'(PERIPH_DIV - 1);

    zcf_state_t st_reg;
    zcf_state_t st_next;

    logic [3:0] event_sample_count;
    logic [3:0] blanking_window_len;
    logic [1:0] sample_rate_select;
    logic [1:0] tacho_edge_select;
    logic zero_cross_sample_gate, encoder_capture_source, unused_input_state, sr, independent_phase_cfg, motor_output_enable, pwms;
    logic ptick, scf_tick, zstrobe, zgate, z_ok, sel_unused;

    function automatic logic [9:0] win_ticks(input logic [3:0] code);
        if (code < zcf_pkg::WIN_CODE_SPLIT) begin
            win_ticks = 10'(({6'h0, code} + 10'h001)
                * zcf_pkg::WIN_LO_TICKS);
        end else begin
            win_ticks = 10'(zcf_pkg::WIN_HI_BASE_TICKS
                + {6'h0, code - zcf_pkg::WIN_CODE_SPLIT}
                * zcf_pkg::WIN_HI_TICKS);
        end
    endfunction

    function automatic logic [5:0] presc_last(input logic [1:0] sel);
        presc_last = 6'((zcf_pkg::SCF_BASE_TICKS << sel) - 6'h01);
    endfunction

    assign event_sample_count = st_reg.zf_cfg[zcf_pkg::ZEF_LSB +: 4];
    assign blanking_window_len = st_reg.zf_cfg[zcf_pkg::ZWF_LSB +: 4];
    assign zero_cross_sample_gate = st_reg.sc_cfg[zcf_pkg::ZSV_BIT];
    assign sample_rate_select = st_reg.sc_cfg[zcf_pkg::SCF_LSB +: 2];
    assign encoder_capture_source = st_reg.sc_cfg[zcf_pkg::ECM_BIT];
    assign unused_input_state = st_reg.sc_cfg[zcf_pkg::UNUSED_INPUT_STATE_BIT];
    assign sr = st_reg.ctrl[zcf_pkg::CTL_SR_BIT];
    assign independent_phase_cfg = st_reg.ctrl[zcf_pkg::CTL_PCN_BIT];
    assign tacho_edge_select = st_reg.ctrl[zcf_pkg::CTL_TES_LSB +: 2];
    assign motor_output_enable = st_reg.ctrl[zcf_pkg::CTL_MOE_BIT];
    assign pwms = st_reg.ctrl[zcf_pkg::CTL_PWMS_BIT];

    // =========================================================
    // Next state
    // =========================================================
    always_comb begin
        st_next = st_reg;
        // Peripheral tick; the divider is a parameter so benches can
        // shorten the long blanking windows.
        ptick = (st_reg.pdiv == PDIV_LAST); // R05
        st_next.pdiv = ptick ? 6'h00 : 6'(st_reg.pdiv + 6'h01);
        scf_tick = ptick && (st_reg.presc == presc_last(sample_rate_select)); // R08
        if (ptick) begin
            st_next.presc = scf_tick ? 6'h00 : 6'(st_reg.presc + 6'h01);
        end
        zstrobe = pwms ? pwm_period : scf_tick; // R02
        zgate = motor_output_enable | zero_cross_sample_gate; // R06
        z_ok = zstrobe && zgate && !st_reg.blank; // R03
        st_next.z_event = 1'b0;
        if (d_event && !sr) begin
            st_next.win_cnt = win_ticks(blanking_window_len); // R04
            st_next.run = 5'h00;
        end else begin
            if (ptick && st_reg.win_cnt != 10'h000) begin
                st_next.win_cnt = 10'(st_reg.win_cnt - 10'h001);
            end
            if (z_ok) begin
                if (!z_detect) begin
                    st_next.run = 5'h00; // R14
                end else if (st_reg.run == {1'b0, event_sample_count}) begin
                    st_next.z_event = 1'b1; // R01
                    st_next.run = 5'(st_reg.run + 5'h01);
                end else if (st_reg.run < {1'b0, event_sample_count}) begin
                    st_next.run = 5'(st_reg.run + 5'h01);
                end
            end
        end
        st_next.blank = (st_next.win_cnt != 10'h000); // R03
        // Capture only matters in speed sensor mode.
        st_next.enc_cap = (tacho_edge_select != zcf_pkg::TES_POSITION_MODE)
            && (encoder_capture_source ? timer_high_read : rtc_irq); // R09
        sel_unused = !independent_phase_cfg && (tacho_edge_select == zcf_pkg::TES_POSITION_MODE)
            && !sr; // R10 R12 R13
        st_next.gnd = sel_unused && !unused_input_state;
        st_next.hiz = sel_unused && unused_input_state;

        // Write path: address and data are taken in either order.
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.awready && s_axi_awvalid) begin
            st_next.aw_have = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (st_reg.wready && s_axi_wvalid) begin
            st_next.w_have = 1'b1;
            st_next.wdata = s_axi_wdata[7:0];
            st_next.wstrb0 = s_axi_wstrb[0];
        end
        if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
            st_next.aw_have = 1'b0;
            st_next.w_have = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = zcf_pkg::RESP_OKAY;
            case (st_reg.awaddr)
                zcf_pkg::ADDR_ZF_CFG: begin
                    if (st_reg.wstrb0) begin
                        st_next.zf_cfg = st_reg.wdata;
                    end
                end
                zcf_pkg::ADDR_SC_CFG: begin
                    // Reserved bits are dropped so they always read zero.
                    if (st_reg.wstrb0) begin
                        st_next.sc_cfg = st_reg.wdata & zcf_pkg::SC_WMASK;
                    end
                end
                zcf_pkg::ADDR_CTRL: begin
                    if (st_reg.wstrb0) begin
                        st_next.ctrl = st_reg.wdata & zcf_pkg::CTRL_WMASK;
                    end
                end
                zcf_pkg::ADDR_STATUS: begin
                end
                default: begin
                    st_next.bresp = zcf_pkg::RESP_DECERR;
                end
            endcase
        end
        st_next.awready = !st_next.aw_have;
        st_next.wready = !st_next.w_have;

        // Read path.
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (st_reg.arready && s_axi_arvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = zcf_pkg::RESP_OKAY;
            case (s_axi_araddr)
                zcf_pkg::ADDR_ZF_CFG: st_next.rdata = {24'h0, st_reg.zf_cfg};
                zcf_pkg::ADDR_SC_CFG: st_next.rdata = {24'h0, st_reg.sc_cfg};
                zcf_pkg::ADDR_CTRL: st_next.rdata = {24'h0, st_reg.ctrl};
                zcf_pkg::ADDR_STATUS: begin
                    st_next.rdata = (32'(st_reg.run) << zcf_pkg::STAT_RUN_LSB)
                        | 32'(st_reg.blank);
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rresp = zcf_pkg::RESP_DECERR;
                end
            endcase
        end
        st_next.arready = !st_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.zf_cfg <= zcf_pkg::RST_ZF_CFG; // R11
            st_reg.sc_cfg <= zcf_pkg::RST_SC_CFG; // R11
            st_reg.ctrl <= zcf_pkg::RST_CTRL;
        end else begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rresp = st_reg.rresp;
    assign s_axi_rdata = st_reg.rdata;
    assign z_event = st_reg.z_event;
    assign z_blanking = st_reg.blank;
    assign encoder_capture = st_reg.enc_cap;
    assign unused_input_gnd = st_reg.gnd;
    assign unused_input_hiz = st_reg.hiz;

    // =========================================================
    // Assertions
    // =========================================================
    sequence seq_ptick_gap;
        ptick ##1 !ptick [*2];
    endsequence

    AST_PTICK_SPACING: assert property (@(posedge aclk) // R05
        disable iff (!aresetn) ptick |-> seq_ptick_gap)
        else $error("peripheral tick repeats too soon");

    AST_RESET_VALUES: assert property (@(posedge aclk) // R11
        disable iff (!aresetn) $past(!aresetn) |->
        (st_reg.zf_cfg == zcf_pkg::RST_ZF_CFG)
        && (st_reg.sc_cfg == zcf_pkg::RST_SC_CFG))
        else $error("config registers not at reset value");

    AST_EVENT_RUN: assert property (@(posedge aclk) // R01
        disable iff (!aresetn) st_reg.z_event |->
        $past(z_ok && z_detect && !(d_event && !sr)
        && st_reg.run == {1'b0, event_sample_count}))
        else $error("Z event without a full run of samples");

    AST_RUN_RESTART: assert property (@(posedge aclk) // R14
        disable iff (!aresetn) z_ok && !z_detect |=> st_reg.run == 5'h00)
        else $error("missed sample did not restart the count");

    AST_PWM_SOURCE: assert property (@(posedge aclk) // R02
        disable iff (!aresetn) pwms && !pwm_period |->
        ##1 $stable(st_reg.run) || $past(d_event))
        else $error("count moved without a PWM strobe");

    AST_GATE_OFF: assert property (@(posedge aclk) // R06
        disable iff (!aresetn) !motor_output_enable && !zero_cross_sample_gate && !d_event |=>
        $stable(st_reg.run))
        else $error("Z sampled while gated off");

    AST_WIN_LOAD: assert property (@(posedge aclk) // R04
        disable iff (!aresetn) d_event && !sr |=>
        st_reg.blank && st_reg.win_cnt == win_ticks($past(blanking_window_len)))
        else $error("blanking window length wrong");

    AST_NO_WIN_ALT: assert property (@(posedge aclk) // R04
        disable iff (!aresetn) d_event && sr && !st_reg.blank |=>
        !st_reg.blank)
        else $error("window applied in alternate mode");

    AST_BLANK_IGNORE: assert property (@(posedge aclk) // R03
        disable iff (!aresetn) st_reg.blank |=> !st_reg.z_event)
        else $error("Z event during blanking window");

    AST_CAPTURE: assert property (@(posedge aclk) // R09
        disable iff (!aresetn) tacho_edge_select != zcf_pkg::TES_POSITION_MODE
        && encoder_capture_source && timer_high_read |=> encoder_capture)
        else $error("timer read did not trigger capture");

    AST_UNUSED_OFF: assert property (@(posedge aclk) // R10
        disable iff (!aresetn) independent_phase_cfg || sr |=>
        !unused_input_gnd && !unused_input_hiz)
        else $error("unused input selection active when not allowed");

endmodule

/* File: hw/zcf_pkg.sv */
package zcf_pkg;

    // =========================================================
    // Clocking and time base
    // =========================================================
    localparam int ACLK_HZ = 200_000_000;
    localparam int PERIPH_HZ = 4_000_000;
    localparam int PERIPH_DIV = ACLK_HZ / PERIPH_HZ;
    localparam int NS_PER_US = 1000;
    localparam int PTICKS_PER_US = PERIPH_HZ / 1_000_000;
    localparam int SCF_BASE_NS = 1000;
    localparam int WIN_LO_STEP_NS = 5000;
    localparam int WIN_HI_BASE_NS = 60000;
    localparam int WIN_HI_STEP_NS = 20000;
    localparam logic [5:0] SCF_BASE_TICKS =
        6'(SCF_BASE_NS * PTICKS_PER_US / NS_PER_US);
    localparam logic [9:0] WIN_LO_TICKS =
        10'(WIN_LO_STEP_NS * PTICKS_PER_US / NS_PER_US);
    localparam logic [9:0] WIN_HI_BASE_TICKS =
        10'(WIN_HI_BASE_NS * PTICKS_PER_US / NS_PER_US);
    localparam logic [9:0] WIN_HI_TICKS =
        10'(WIN_HI_STEP_NS * PTICKS_PER_US / NS_PER_US);
    localparam logic [3:0] WIN_CODE_SPLIT = 4'h8;

    // =========================================================
    // Register map
    // =========================================================
    localparam logic [7:0] ADDR_ZF_CFG = 8'h00;
    localparam logic [7:0] ADDR_SC_CFG = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] RST_ZF_CFG = 8'h0F;
    localparam logic [7:0] RST_SC_CFG = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] SC_WMASK = 8'h8F;
    localparam logic [7:0] CTRL_WMASK = 8'h3F;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // =========================================================
    // Field positions
    // =========================================================
    localparam int ZEF_LSB = 4;
    localparam int ZWF_LSB = 0;
    localparam int ZSV_BIT = 7;
    localparam int SCF_LSB = 2;
    localparam int ECM_BIT = 1;
    localparam int UNUSED_INPUT_STATE_BIT = 0;
    localparam int CTL_SR_BIT = 0;
    localparam int CTL_PCN_BIT = 1;
    localparam int CTL_TES_LSB = 2;
    localparam int CTL_MOE_BIT = 4;
    localparam int CTL_PWMS_BIT = 5;
    localparam int STAT_RUN_LSB = 8;
    localparam logic [1:0] TES_POSITION_MODE = 2'h0;

endpackage

/* File: test/zcf_phase_model.sv */
`timescale 1ns/1ps
module zcf_phase_model (
    // Clock
    input wire logic aclk,
    // Comparator and event lines
    output logic z_detect,
    output logic d_event,
    output logic pwm_period,
    output logic rtc_irq,
    output logic timer_high_read
);
    initial begin
        z_detect = 1'b0;
        {d_event, pwm_period, rtc_irq, timer_high_read} = 4'h0;
    end

    // Event lines are single-cycle pulses; a held line would repeat.
    task automatic pulse(input int which);
        @(posedge aclk);
        case (which)
            0: d_event <= 1'b1;
            1: pwm_period <= 1'b1;
            2: rtc_irq <= 1'b1;
            default: timer_high_read <= 1'b1;
        endcase
        @(posedge aclk);
        {d_event, pwm_period, rtc_irq, timer_high_read} <= 4'h0;
    endtask

    task automatic level(input logic det);
        @(posedge aclk);
        z_detect <= det;
    endtask
endmodule

/* File: test/tb_zero_cross_event_filter.sv */
`timescale 1ns/1ps
module tb_zero_cross_event_filter;
    localparam int D = 5;
    localparam int LIM = 6000;
    localparam logic [7:0] AZ = zcf_pkg::ADDR_ZF_CFG;
    localparam logic [7:0] AS = zcf_pkg::ADDR_SC_CFG;
    localparam logic [7:0] AC = zcf_pkg::ADDR_CTRL;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic z_detect, d_event, pwm_period, rtc_irq, timer_high_read;
    logic z_event, z_blanking, encoder_capture;
    logic unused_input_gnd, unused_input_hiz;
    int fail_count = 0, samples_checked = 0;
    int zev = 0, cap = 0, blk = 0;
    int seed = 32'h3381;
    logic [33:0] rq[$];

    always #2.5 aclk = ~aclk;

    zcf_top #(.PERIPH_DIV(D)) dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .z_detect, .d_event, .pwm_period, .rtc_irq, .timer_high_read,
        .z_event, .z_blanking, .encoder_capture, .unused_input_gnd,
        .unused_input_hiz);
    zcf_phase_model pm (.aclk, .z_detect, .d_event, .pwm_period,
        .rtc_irq, .timer_high_read);

    // =========================================================
    // Checking
    // =========================================================
    task automatic cmp(input logic [33:0] g, input logic [33:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic inr(input int g, input int lo, input int hi);
        samples_checked++;
        if (g < lo || g > hi) begin
            fail_count++;
            $display("BAD %0t %0d not in %0d..%0d", $time, g, lo, hi);
        end
    endtask

    task automatic conclude;
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic bust;
        fail_count++;
        $display("BAD %0t wait ran out", $time);
        conclude();
    endtask

    // Read answers are matched against the oldest expectation noted.
    always @(posedge aclk) begin
        if (z_event === 1'b1) zev <= zev + 1;
        if (encoder_capture === 1'b1) cap <= cap + 1;
        if (z_blanking === 1'b1) blk <= blk + 1;
        if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
            if (rq.size() == 0) bust();
            else cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        end
    end

    // =========================================================
    // Bus and stimulus
    // =========================================================
    // Response readies come up after a random delay to exercise holding.
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] r = 2'h0, input logic st = 1'b1);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'($random(seed)), d};
        s_axi_wstrb <= {3'($random(seed)), st};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($random(seed));
        for (n = 0; n < LIM && (s_axi_awvalid || s_axi_wvalid ||
             s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1); n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (!s_axi_bready) s_axi_bready <= 1'($random(seed));
        end
        if (n == LIM) bust();
        s_axi_bready <= 1'b0;
        cmp({32'h0, s_axi_bresp}, {32'h0, r});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] r = 2'h0);
        int n;
        rq.push_back({r, 24'h0, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($random(seed));
        for (n = 0; n < LIM && (s_axi_arvalid ||
             s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1); n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (!s_axi_rready) s_axi_rready <= 1'($random(seed));
        end
        if (n == LIM) bust();
        s_axi_rready <= 1'b0;
    endtask

    task automatic smp(input logic det);
        pm.level(det);
        pm.pulse(1);
    endtask

    initial begin
        int i, n, z0, ex, run, zf, t;
        logic det;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(AZ, 8'h0F);
        rd(AS, 8'h00);
        rd(zcf_pkg::ADDR_STATUS, 8'h00);
        rd(8'h10, 8'h00, 2'h3);
        wr(8'h10, 8'h55, 2'h3);
        wr(AS, 8'h8F);
        rd(AS, 8'h8F);
        // A write with the low byte strobe clear must not store.
        wr(AS, 8'h00, 2'h0, 1'b0);
        rd(AS, 8'h8F);
        for (i = 0; i < 5; i++) begin
            wr(AC, i == 2 ? 8'h02 : i == 3 ? 8'h01 : i == 4 ? 8'h04 : 8'h00);
            wr(AS, i > 0 ? 8'h01 : 8'h00);
            repeat (3) @(posedge aclk);
            ex = i == 0 ? 2 : i == 1 ? 1 : 0;
            cmp({unused_input_gnd, unused_input_hiz}, 34'(ex));
        end
        for (i = 0; i < 2; i++) begin
            wr(AS, i ? 8'h02 : 8'h00);
            z0 = cap;
            pm.pulse(2);
            repeat (3) @(posedge aclk);
            cmp(34'(cap - z0), 34'(i == 0));
            pm.pulse(3);
            repeat (3) @(posedge aclk);
            cmp(34'(cap - z0), 34'h1);
        end
        // Pulse-rate sampling: one unbroken run of detections, then random runs.
        wr(AC, 8'h30);
        wr(AS, 8'h00);
        for (t = 0; t < 4; t++) begin
            zf = t == 0 ? 15 : t == 1 ? 0 : $random(seed) & 15;
            wr(AZ, 8'(zf << 4));
            smp(1'b0);
            z0 = zev;
            ex = 0;
            run = 0;
            for (i = 0; i < 24; i++) begin
                det = t == 0 ? 1'b1 : ($random(seed) & 3) != 0;
                run = det ? run + 1 : 0;
                if (run == zf + 1) ex++;
                smp(det);
            end
            repeat (3) @(posedge aclk);
            cmp(34'(zev - z0), 34'(ex));
        end
        wr(AC, 8'h20);
        wr(AZ, 8'h00);
        for (i = 0; i < 2; i++) begin
            wr(AS, i ? 8'h80 : 8'h00);
            z0 = zev;
            smp(1'b0);
            smp(1'b1);
            repeat (3) @(posedge aclk);
            cmp(34'(zev - z0), 34'(i));
        end
        wr(AC, 8'h30);
        for (i = 0; i < 4; i++) begin
            zf = i == 0 ? 0 : i == 1 ? 7 : i == 2 ? 8 : 15;
            wr(AZ, 8'(zf));
            smp(1'b0);
            z0 = zev;
            n = blk;
            pm.pulse(0);
            smp(1'b1);
            for (run = 0; run < LIM && z_blanking === 1'b1; run++)
                @(posedge aclk);
            if (run == LIM) bust();
            cmp(34'(zev - z0), 34'h0);
            t = zf < 8 ? (zf + 1) * 20 : 240 + (zf - 8) * 80;
            inr(blk - n, (t - 1) * D, t * D + 2);
            smp(1'b1);
            repeat (3) @(posedge aclk);
            cmp(34'(zev - z0), 34'h1);
        end
        wr(AC, 8'h31);
        n = blk;
        pm.pulse(0);
        repeat (5) @(posedge aclk);
        cmp(34'(blk - n), 34'h0);
        // Rate-clock sampling: two samples are needed, P apart.
        wr(AC, 8'h10);
        wr(AZ, 8'h10);
        for (i = 0; i < 4; i++) begin
            wr(AS, 8'(i << 2));
            t = (4 << i) * D;
            pm.level(1'b0);
            repeat (2 * t + 5) @(posedge aclk);
            z0 = zev;
            pm.level(1'b1);
            for (n = 0; n < LIM && zev == z0; n++)
                @(posedge aclk);
            inr(n, t - 1, 2 * t + 3);
        end
        conclude();
    end
endmodule
